/* File: rtl/fps_pkg.sv */
// constants shared by the flash page program sequencer
package fps_pkg;
   // ****************************************************
   // register map on the wishbone slave (byte addresses)
   // ****************************************************
   localparam logic [7:0] FCTL_OFS = 8'h00; // flash_control_reg
   localparam logic [7:0] FSTS_OFS = 8'h04; // flash_status_reg
   localparam logic [7:0] AUX1_OFS = 8'h08; // auxiliary_reg_one
   // flash_control_reg fields
   localparam int FCTL_BUSY_BIT = 0;
   localparam int FCTL_SEL_LO = 1; // space_select_low
   localparam int FCTL_SEL_HI = 2; // space_select_high
   localparam int FCTL_MAP_BIT = 3; // latch_space_map_bit
   // flash_status_reg fields
   localparam int FSTS_LOAD_BIT = 0; // latch_loaded_flag
   localparam int FSTS_SERR_BIT = 1; // sequence_error_flag
   // auxiliary_reg_one fields
   localparam int AUX1_BOOT_BIT = 5; // boot_flash_map_bit
   localparam logic AUX1_BOOT_RST = 1'b1;
   // ****************************************************
   // command nibbles and operation selectors
   // ****************************************************
   localparam logic [3:0] CMD_FIRST = 4'h5;
   localparam logic [3:0] CMD_SECOND = 4'ha;
   localparam logic [3:0] OP_USER = 4'h0;
   localparam logic [3:0] OP_XROW = 4'h2;
   localparam logic [3:0] OP_SECB = 4'h4;
   localparam logic [3:0] OP_LCLR = 4'h6;
   // space select values (high bit, low bit)
   localparam logic [1:0] SEL_USER = 2'b00;
   localparam logic [1:0] SEL_XROW = 2'b01;
   localparam logic [1:0] SEL_SECB = 2'b10;
   // ****************************************************
   // code space map and sources
   // ****************************************************
   localparam logic [15:0] BOOT_BASE = 16'hf800;
   localparam logic [15:0] XROW_BASE = 16'hff80;
   localparam logic [15:0] SECB_ADDR = 16'h0000;
   typedef enum logic [1:0] {
      FPS_SRC_USER = 2'b00,
      FPS_SRC_BOOT = 2'b01,
      FPS_SRC_XROW = 2'b10,
      FPS_SRC_SECB = 2'b11
   } fps_src_e;
   // ****************************************************
   // timing: per-byte erase and write times
   // ****************************************************
   localparam int CLK_MHZ = 125;
   localparam int ERASE_NS = 64;
   localparam int WRITE_NS = 64;
   localparam int ERASE_CYC = (ERASE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_CYC = (WRITE_NS * CLK_MHZ + 999) / 1000;
endpackage

/* File: rtl/fps_latch_buf.sv */
// column latch page buffer with per-byte loaded markers
`timescale 1ns/1ps
`default_nettype none
module fps_latch_buf #(
   parameter int PAGE_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [15:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic clear_i,
   input wire logic [PAGE_W-1:0] ridx_i,
   output logic [7:0] rdata_o,
   output logic rloaded_o,
   output logic any_o,
   output logic [15-PAGE_W:0] page_o
);
   localparam int N = 1 << PAGE_W;
   logic [7:0] data_q [0:N-1];
   logic [N-1:0] loaded_q;
   logic [15-PAGE_W:0] page_q;

   // data bytes; clear wins over a load in the same cycle
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < N; i++) begin
         if (rst_i || clear_i) begin
            data_q[i] <= 8'h00;
         end else if (wr_i && waddr_i[PAGE_W-1:0] == i[PAGE_W-1:0]) begin
            data_q[i] <= wdata_i;
         end
      end
   end

   // loaded markers and the page of the most recent load
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         loaded_q <= '0;
         page_q <= '0;
      end else if (wr_i) begin
         loaded_q[waddr_i[PAGE_W-1:0]] <= 1'b1;
         page_q <= waddr_i[15:PAGE_W]; // last load picks the page
      end
   end

   assign rdata_o = data_q[ridx_i];
   assign rloaded_o = loaded_q[ridx_i];
   assign any_o = |loaded_q;
   assign page_o = page_q;
endmodule
`default_nettype wire

/* File: rtl/fps_sequencer.sv */
// flash page program sequencer: control/status registers, command decode, program walk
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer #(
   parameter int PAGE_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // core side: fetch location and external data writes
   input wire logic fetch_boot_i,
   input wire logic xd_we_i,
   input wire logic [15:0] xd_addr_i,
   input wire logic [7:0] xd_data_i,
   output logic xd_latch_o,
   // code space read steering
   input wire logic [15:0] code_addr_i,
   output logic [1:0] code_src_o,
   // flash array strobes
   output logic fl_erase_o,
   output logic fl_write_o,
   output logic [1:0] fl_space_o,
   output logic [15:0] fl_addr_o,
   output logic [7:0] fl_data_o
);
   // ****************************************************
   // state and declarations
   // ****************************************************
   typedef enum logic [1:0] {
      FPS_IDLE = 2'b00,
      FPS_ERASE = 2'b01,
      FPS_WRITE = 2'b11,
      FPS_DONE = 2'b10
   } fps_state_e;
   localparam logic [PAGE_W-1:0] LAST_IDX = '1;
   localparam logic [7:0] ERASE_LD = 8'(fps_pkg::ERASE_CYC - 1);
   localparam logic [7:0] WRITE_LD = 8'(fps_pkg::WRITE_CYC - 1);

   fps_state_e state_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic map_q;
   logic [1:0] sel_q;
   logic boot_q;
   logic serr_q;
   logic armed_q;
   logic [3:0] arm_op_q;
   logic [1:0] space_q;
   logic [PAGE_W-1:0] idx_q;
   logic [7:0] tmr_q;
   logic issued_q;
   logic [1:0] src_q;
   logic fl_erase_q;
   logic fl_write_q;
   logic [15:0] fl_addr_q;
   logic [7:0] fl_data_q;
   logic busy;
   logic wb_wr;
   logic fctl_wr;
   logic sw_serr_clr;
   logic other_wr;
   logic cmd_match;
   logic prog_op;
   logic launch_ok;
   logic lclr_op;
   logic serr_set;
   logic lat_wr;
   logic lat_clr;
   logic [7:0] lat_rdata;
   logic lat_rloaded;
   logic lat_any;
   logic [15-PAGE_W:0] lat_page;
   logic step_free;

   // ****************************************************
   // wishbone slave: one wait state, ack for one cycle
   // ****************************************************
   // writes act on the edge where the master samples ack
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
   assign fctl_wr = wb_wr && wb_adr_i == fps_pkg::FCTL_OFS;
   assign other_wr = wb_wr && wb_adr_i != fps_pkg::FCTL_OFS;
   assign sw_serr_clr = wb_wr && wb_adr_i == fps_pkg::FSTS_OFS && wb_dat_i[fps_pkg::FSTS_SERR_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   // read data captured with the ack; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         dat_q <= 32'h0000_0000;
         case (wb_adr_i)
            fps_pkg::FCTL_OFS: begin
               dat_q[fps_pkg::FCTL_BUSY_BIT] <= busy;
               dat_q[fps_pkg::FCTL_SEL_LO] <= sel_q[0];
               dat_q[fps_pkg::FCTL_SEL_HI] <= sel_q[1];
               dat_q[fps_pkg::FCTL_MAP_BIT] <= map_q;
            end
            fps_pkg::FSTS_OFS: begin
               dat_q[fps_pkg::FSTS_LOAD_BIT] <= lat_any;
               dat_q[fps_pkg::FSTS_SERR_BIT] <= serr_q;
            end
            fps_pkg::AUX1_OFS: begin
               dat_q[fps_pkg::AUX1_BOOT_BIT] <= boot_q;
            end
            default: begin
               dat_q <= 32'h0000_0000;
            end
         endcase
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ****************************************************
   // control and auxiliary register fields
   // ****************************************************
   // every control write updates map and select, command bytes too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         map_q <= 1'b0;
         sel_q <= fps_pkg::SEL_USER;
      end else if (fctl_wr) begin
         map_q <= wb_dat_i[fps_pkg::FCTL_MAP_BIT];
         sel_q <= {wb_dat_i[fps_pkg::FCTL_SEL_HI], wb_dat_i[fps_pkg::FCTL_SEL_LO]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_q <= fps_pkg::AUX1_BOOT_RST;
      end else if (wb_wr && wb_adr_i == fps_pkg::AUX1_OFS) begin
         boot_q <= wb_dat_i[fps_pkg::AUX1_BOOT_BIT];
      end
   end

   // ****************************************************
   // two-byte command decode
   // ****************************************************
   // a second byte must repeat the first byte's low nibble
   assign cmd_match = armed_q && fctl_wr && wb_dat_i[7:4] == fps_pkg::CMD_SECOND
                      && wb_dat_i[3:0] == arm_op_q;
   assign prog_op = arm_op_q == fps_pkg::OP_USER || arm_op_q == fps_pkg::OP_XROW
                    || arm_op_q == fps_pkg::OP_SECB;
   assign lclr_op = cmd_match && arm_op_q == fps_pkg::OP_LCLR && fetch_boot_i;
   assign launch_ok = cmd_match && prog_op && fetch_boot_i && lat_any;

   // any write between the two bytes breaks the pair
   assign serr_set = (armed_q && (other_wr || xd_we_i
                      || (fctl_wr && !cmd_match)))
                     || (cmd_match && prog_op && (!lat_any || !fetch_boot_i))
                     || (cmd_match && arm_op_q == fps_pkg::OP_LCLR && !fetch_boot_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_q <= 1'b0;
         arm_op_q <= 4'h0;
      end else if (fctl_wr) begin
         // commands are not taken while a program runs
         armed_q <= !busy && !armed_q && wb_dat_i[7:4] == fps_pkg::CMD_FIRST;
         arm_op_q <= wb_dat_i[3:0];
      end else if (other_wr || xd_we_i) begin
         armed_q <= 1'b0;
      end
   end

   // error flag: a new error wins over either clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serr_q <= 1'b0;
      end else if (serr_set) begin
         serr_q <= 1'b1;
      end else if (sw_serr_clr || state_q == FPS_DONE) begin
         serr_q <= 1'b0;
      end
   end

   // ****************************************************
   // column latches
   // ****************************************************
   assign xd_latch_o = xd_we_i && map_q;
   assign lat_wr = xd_we_i && map_q && !busy;
   assign lat_clr = lclr_op || state_q == FPS_DONE;

   fps_latch_buf #(
      .PAGE_W(PAGE_W)
   ) u_latch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(lat_wr),
      .waddr_i(xd_addr_i),
      .wdata_i(xd_data_i),
      .clear_i(lat_clr),
      .ridx_i(idx_q),
      .rdata_o(lat_rdata),
      .rloaded_o(lat_rloaded),
      .any_o(lat_any),
      .page_o(lat_page)
   );

   // ****************************************************
   // program walk: erase pass, then write pass
   // ****************************************************
   assign busy = state_q != FPS_IDLE;
   assign step_free = tmr_q == 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= FPS_IDLE;
         idx_q <= '0;
         tmr_q <= 8'h00;
         issued_q <= 1'b0;
         space_q <= fps_pkg::SEL_USER;
      end else begin
         case (state_q)
            FPS_IDLE: begin
               if (launch_ok) begin
                  state_q <= FPS_ERASE;
                  idx_q <= '0;
                  issued_q <= 1'b0;
                  space_q <= arm_op_q[2:1];
               end
            end
            FPS_ERASE, FPS_WRITE: begin
               if (!step_free) begin
                  tmr_q <= tmr_q - 8'h01;
               end else if (lat_rloaded && !issued_q) begin
                  issued_q <= 1'b1;
                  tmr_q <= state_q == FPS_ERASE ? ERASE_LD : WRITE_LD;
               end else begin
                  issued_q <= 1'b0;
                  idx_q <= idx_q + 1'b1;
                  if (idx_q == LAST_IDX) begin
                     state_q <= state_q == FPS_ERASE ? FPS_WRITE : FPS_DONE;
                  end
               end
            end
            FPS_DONE: begin
               state_q <= FPS_IDLE;
            end
            default: begin
               state_q <= FPS_IDLE;
            end
         endcase
      end
   end

   // strobes are one cycle per loaded byte; unloaded bytes are skipped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fl_erase_q <= 1'b0;
         fl_write_q <= 1'b0;
         fl_addr_q <= 16'h0000;
         fl_data_q <= 8'h00;
      end else begin
         fl_erase_q <= state_q == FPS_ERASE && step_free && lat_rloaded && !issued_q;
         fl_write_q <= state_q == FPS_WRITE && step_free && lat_rloaded && !issued_q;
         // the whole page follows the last load address; SEL_SECB space always uses SECB_ADDR
         fl_addr_q <= space_q == fps_pkg::SEL_SECB ? fps_pkg::SECB_ADDR : {lat_page, idx_q};
         fl_data_q <= lat_rdata;
      end
   end
   assign fl_erase_o = fl_erase_q;
   assign fl_write_o = fl_write_q;
   assign fl_addr_o = fl_addr_q;
   assign fl_data_o = fl_data_q;
   assign fl_space_o = space_q;

   // ****************************************************
   // code space read steering
   // ****************************************************
   // registered so the source is valid one cycle after the address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_q <= fps_pkg::FPS_SRC_USER;
      end else if (sel_q == fps_pkg::SEL_XROW && code_addr_i >= fps_pkg::XROW_BASE) begin
         src_q <= fps_pkg::FPS_SRC_XROW;
      end else if (sel_q == fps_pkg::SEL_SECB && code_addr_i == fps_pkg::SECB_ADDR) begin
         src_q <= fps_pkg::FPS_SRC_SECB;
      end else if (boot_q && code_addr_i >= fps_pkg::BOOT_BASE) begin
         src_q <= fps_pkg::FPS_SRC_BOOT;
      end else begin
         src_q <= fps_pkg::FPS_SRC_USER;
      end
   end
   assign code_src_o = src_q;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_armed_break;
      armed_q && fctl_wr && wb_dat_i[7:4] != fps_pkg::CMD_SECOND;
   endsequence
   sequence s_launch;
      launch_ok ##1 busy;
   endsequence

   chk_launch_busy: assert property (launch_ok |-> s_launch)
      else $error("launch did not raise busy");
   chk_empty_launch: assert property (cmd_match && prog_op && !lat_any |=> serr_q && !busy)
      else $error("empty launch not flagged");
   chk_broken_pair: assert property (s_armed_break |=> serr_q)
      else $error("broken command pair not flagged");
   // the done step clears the latches on purpose, so it is left out here
   chk_busy_latch_hold: assert property (busy && state_q != FPS_DONE && xd_we_i
                                         |=> $stable(lat_any) && $stable(lat_page))
      else $error("latches changed while busy");
   chk_done_clears: assert property (state_q == FPS_DONE |=> !lat_any && !busy)
      else $error("latches not cleared after program");
   chk_latch_reset: assert property (lclr_op |=> !lat_any && !busy)
      else $error("latch reset failed");
   // the strobe flop is set on the same edge as issued_q
   chk_loaded_only: assert property ($rose(issued_q) |-> (fl_erase_o || fl_write_o) && $past(lat_rloaded))
      else $error("strobe on unloaded byte");
   chk_page_addr: assert property (fl_write_o && space_q != fps_pkg::SEL_SECB
                                   |-> fl_addr_o[15:PAGE_W] == lat_page)
      else $error("write outside last loaded page");
   chk_map_load: assert property (map_q && xd_we_i && !busy && !lat_clr |=> lat_any)
      else $error("mapped write did not load latch");
   chk_xrow_read: assert property (sel_q == fps_pkg::SEL_XROW && code_addr_i >= fps_pkg::XROW_BASE
                                   |=> code_src_o == fps_pkg::FPS_SRC_XROW)
      else $error("extra row not mapped");
   chk_serr_clear: assert property (sw_serr_clr && !serr_set |=> !serr_q)
      else $error("error flag not cleared");
endmodule
`default_nettype wire

/* File: sim/fps_core_model.sv */
// firmware-side model of the core: external data writes, fetch location, code reads
`timescale 1ns/1ps
`default_nettype none
module fps_core_model (
   input wire logic clk_i,
   output logic fetch_boot_o,
   output logic xd_we_o,
   output logic [15:0] xd_addr_o,
   output logic [7:0] xd_data_o,
   output logic [15:0] code_addr_o
);
   // ****************************************************
   // idle values: firmware runs from boot flash
   // ****************************************************
   initial begin
      fetch_boot_o = 1'b1;
      xd_we_o = 1'b0;
      xd_addr_o = 16'h0000;
      xd_data_o = 8'h00;
      code_addr_o = 16'h0000;
   end
   // one data-pointer-indirect write; lines are scrambled after so stale data never looks valid
   task automatic load(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      xd_we_o <= 1'b1;
      xd_addr_o <= a;
      xd_data_o <= d;
      @(posedge clk_i);
      xd_we_o <= 1'b0;
      xd_addr_o <= ~a;
      xd_data_o <= ~d;
   endtask
   // fetch location: low means the core runs outside boot flash
   task automatic boot(input logic b);
      @(posedge clk_i);
      fetch_boot_o <= b;
   endtask
   // code-space read address, held until the next read
   task automatic fetch(input logic [15:0] a);
      @(posedge clk_i);
      code_addr_o <= a;
   endtask
endmodule
`default_nettype wire

/* File: sim/fps_sequencer_tb.sv */
// self-checking bench for the flash page program sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, fboot, xwe, xlatch, fer, fwr;
   logic [15:0] xaddr, caddr, faddr;
   logic [7:0] xdata, fdata;
   logic [1:0] csrc, fspace;
   int n_errors = 0, checks_done = 0, n_er = 0, n_wr = 0, n_claim = 0;
   logic bad_order = 1'b0;
   logic [15:0] last_wa = 16'h0;
   logic [7:0] last_wd = 8'h0;
   // 8 ns period clock
   always #4 clk_i = ~clk_i;
   // ****************************************************
   // design and core model
   // ****************************************************
   fps_sequencer i_fps_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fetch_boot_i(fboot),
      .xd_we_i(xwe), .xd_addr_i(xaddr), .xd_data_i(xdata), .xd_latch_o(xlatch), .code_addr_i(caddr),
      .code_src_o(csrc), .fl_erase_o(fer), .fl_write_o(fwr), .fl_space_o(fspace), .fl_addr_o(faddr),
      .fl_data_o(fdata));
   fps_core_model i_fps_core_model (.clk_i(clk_i), .fetch_boot_o(fboot), .xd_we_o(xwe), .xd_addr_o(xaddr),
      .xd_data_o(xdata), .code_addr_o(caddr));
   // flash array monitor: an erase after any write breaks erase-then-write order
   always @(posedge clk_i) begin
      if (xlatch === 1'b1) n_claim++;
      if (fer === 1'b1) begin
         n_er++;
         if (n_wr > 0) bad_order = 1'b1;
      end
      if (fwr === 1'b1) begin
         n_wr++;
         last_wa = faddr;
         last_wd = fdata;
      end
   end
   // ****************************************************
   // shared tasks
   // ****************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one classic wishbone cycle; no fixed latency assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) check("ack", 1'b0, 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, q);
      check(name, q, exp);
   endtask
   // poll busy in the control register under a bound
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         wb(1'b0, fps_pkg::FCTL_OFS, 32'h0, q);
         n++;
      end while (q[fps_pkg::FCTL_BUSY_BIT] !== 1'b0 && n < 400);
      check("busy_end", q[0], 1'b0);
   endtask
   task automatic mon_clr;
      n_er = 0;
      n_wr = 0;
      n_claim = 0;
      bad_order = 1'b0;
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset;
      rd_chk("ctl_rst", fps_pkg::FCTL_OFS, 32'h0);
      rd_chk("sts_rst", fps_pkg::FSTS_OFS, 32'h0);
      rd_chk("aux_rst", fps_pkg::AUX1_OFS, 32'h20);
      rd_chk("unmapped", 8'h0c, 32'h0);
   endtask
   // two loads in different pages, a third ignored while busy
   task automatic t_user_prog;
      mon_clr();
      wr(fps_pkg::FCTL_OFS, 8'h08);
      i_fps_core_model.load(16'h1205, 8'h11);
      i_fps_core_model.load(16'h3403, 8'h22);
      rd_chk("loaded", fps_pkg::FSTS_OFS, 32'h1);
      wr(fps_pkg::FCTL_OFS, 8'h50);
      wr(fps_pkg::FCTL_OFS, 8'ha0);
      rd_chk("busy", fps_pkg::FCTL_OFS, 32'h1);
      wr(fps_pkg::FCTL_OFS, 8'h08);
      i_fps_core_model.load(16'h3410, 8'h33);
      wait_idle();
      check("claimed", n_claim, 3);
      check("n_erase", n_er, 2);
      check("n_write", n_wr, 2);
      check("order", bad_order, 1'b0);
      check("page_addr", last_wa, 16'h3405);
      check("page_data", last_wd, 8'h11);
      check("space", fspace, fps_pkg::SEL_USER);
      rd_chk("auto_clr", fps_pkg::FSTS_OFS, 32'h0);
      wr(fps_pkg::FCTL_OFS, 8'h00);
   endtask
   task automatic t_seq_err;
      mon_clr();
      wr(fps_pkg::FCTL_OFS, 8'h50);
      wr(fps_pkg::FCTL_OFS, 8'ha0);
      repeat (20) @(posedge clk_i);
      check("no_prog", n_wr, 0);
      rd_chk("err_empty", fps_pkg::FSTS_OFS, 32'h2);
      wr(fps_pkg::FSTS_OFS, 8'h02);
      rd_chk("err_sw_clr", fps_pkg::FSTS_OFS, 32'h0);
      wr(fps_pkg::FCTL_OFS, 8'h50);
      wr(fps_pkg::FCTL_OFS, 8'h00);
      rd_chk("err_order", fps_pkg::FSTS_OFS, 32'h2);
      wr(fps_pkg::FSTS_OFS, 8'h02);
   endtask
   // launch from outside boot flash is flagged; software clears the error before the latch clear
   task automatic t_latch_reset;
      mon_clr();
      wr(fps_pkg::FCTL_OFS, 8'h08);
      i_fps_core_model.load(16'h0007, 8'h77);
      i_fps_core_model.boot(1'b0);
      wr(fps_pkg::FCTL_OFS, 8'h50);
      wr(fps_pkg::FCTL_OFS, 8'ha0);
      rd_chk("boot_only", fps_pkg::FSTS_OFS, 32'h3);
      i_fps_core_model.boot(1'b1);
      wr(fps_pkg::FSTS_OFS, 8'h02);
      wr(fps_pkg::FCTL_OFS, 8'h56);
      wr(fps_pkg::FCTL_OFS, 8'ha6);
      repeat (20) @(posedge clk_i);
      rd_chk("lclr", fps_pkg::FSTS_OFS, 32'h0);
      check("lclr_nowr", n_er + n_wr, 0);
   endtask
   // both launch bytes carry the same select bits as the mapping write
   task automatic space_prog(input logic [7:0] ctl, input logic [3:0] op, input logic [15:0] a,
         input logic [1:0] sp);
      mon_clr();
      wr(fps_pkg::FCTL_OFS, ctl);
      i_fps_core_model.load(a, 8'h5a);
      wr(fps_pkg::FSTS_OFS, 8'h00);
      wr(fps_pkg::FCTL_OFS, {fps_pkg::CMD_FIRST, op});
      wr(fps_pkg::FCTL_OFS, {fps_pkg::CMD_SECOND, op});
      wait_idle();
      rd_chk("sp_err", fps_pkg::FSTS_OFS, 32'h0);
      check("sp_space", fspace, sp);
      check("sp_addr", last_wa, a);
      check("sp_count", n_wr, 1);
      wr(fps_pkg::FCTL_OFS, 8'h00);
   endtask
   task automatic t_spaces;
      wr(fps_pkg::FCTL_OFS, 8'h50);
      wr(fps_pkg::FCTL_OFS, 8'h00);
      space_prog(8'h0a, fps_pkg::OP_XROW, 16'hff85, fps_pkg::SEL_XROW);
      rd_chk("err_hw_clr", fps_pkg::FSTS_OFS, 32'h0);
      space_prog(8'h0c, fps_pkg::OP_SECB, fps_pkg::SECB_ADDR, fps_pkg::SEL_SECB);
   endtask
   task automatic src_chk(input string name, input logic [15:0] a, input logic [1:0] exp);
      i_fps_core_model.fetch(a);
      repeat (2) @(posedge clk_i);
      check(name, csrc, exp);
   endtask
   task automatic t_read_map;
      wr(fps_pkg::FCTL_OFS, 8'h02);
      src_chk("xrow_map", 16'hff80, fps_pkg::FPS_SRC_XROW);
      wr(fps_pkg::FCTL_OFS, 8'h04);
      src_chk("secb_map", 16'h0000, fps_pkg::FPS_SRC_SECB);
      wr(fps_pkg::FCTL_OFS, 8'h00);
      src_chk("user_low", 16'h0000, fps_pkg::FPS_SRC_USER);
      src_chk("boot_hi", 16'hf800, fps_pkg::FPS_SRC_BOOT);
      src_chk("boot_below", 16'hf7ff, fps_pkg::FPS_SRC_USER);
      wr(fps_pkg::AUX1_OFS, 8'h00);
      src_chk("boot_off", 16'hffff, fps_pkg::FPS_SRC_USER);
   endtask
   // firmware waits for the flash to go idle and checks the latches are empty before power down
   task automatic t_power_down;
      wait_idle();
      rd_chk("pd_ready", fps_pkg::FSTS_OFS, 32'h0);
   endtask
   // ****************************************************
   // sequence, watchdog and verdict
   // ****************************************************
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_user_prog();
      t_seq_err();
      t_latch_reset();
      t_spaces();
      t_read_map();
      t_power_down();
      conclude();
   end
   // whole run needs about a thousand cycles; 40000 is ample
   initial begin
      #(8 * 40000);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
